// File: design/lbr_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef LBR_MAP_SVH
`define LBR_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define LBR_OFS_CTRL 8'h00
`define LBR_OFS_PRIMARY 8'h01
`define LBR_OFS_SECONDARY 8'h02
`define LBR_OFS_PIN_FUNC 8'h03

// ----------------------------------------
// General control fields
// ----------------------------------------
`define LBR_CTRL_UNISON 0
`define LBR_CTRL_PRIMARY_ON 1
`define LBR_CTRL_SECONDARY_ON 2
`define LBR_CTRL_RATE_LO 3
`define LBR_CTRL_RATE_HI 4
`define LBR_CTRL_PANEL 5
`define LBR_CTRL_FILL 2'h3

// ----------------------------------------
// Pin function fields
// ----------------------------------------
`define LBR_PF_ENABLE 0
`define LBR_PF_MODE 1
`define LBR_PF_DATA 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LBR_CTRL_RESET 6'h00
`define LBR_LEVEL_RESET 8'h00
`define LBR_PF_RESET 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define LBR_CLK_MHZ 125
`define LBR_STEP0_US 51
`define LBR_STEP1_MS 13
`define LBR_STEP2_MS 26
`define LBR_STEP3_MS 52

`endif

// File: design/lbr_pkg.sv
// Types shared by the brightness ramp controller
`default_nettype none
package lbr_pkg;
  typedef logic [4:0] lbr_code_t;
  typedef enum logic [3:0] {
    LBR_IDLE = 4'h0,
    LBR_ADDR = 4'h1,
    LBR_ACK_A = 4'h3,
    LBR_REG = 4'h2,
    LBR_ACK_R = 4'h6,
    LBR_WDATA = 4'h7,
    LBR_ACK_W = 4'h5,
    LBR_RDATA = 4'h4,
    LBR_RACK = 4'hC
  } lbr_bus_state_t;
endpackage
`default_nettype wire

// File: design/lbr_ctrl.sv
// LED brightness ramp, sink gating, shared pin and serial register access
// Overview of operation
// (R1) Rate bits pick dwell per code: 51us, 13ms, 26ms or 52ms.
// (R2) Selected rate applies to both sinks whenever their level codes change.
// (R3) Active code moves one code per step toward its target.
// (R4) First step of a transition happens at once, without a dwell.
// (R5) Setting a sink enable ramps it up from off to the stored code.
// (R6) Clearing an enable mid-ramp stops rising and fades the sink to off.
// (R7) A code written mid-ramp waits until the earlier target is reached.
// (R8) Rate change mid-ramp continues from present code with the new dwell.
// (R9) Pin function enable clear makes the shared pin an active-low reset.
// (R10) Enabled input mode returns the sampled pin level in bit 2.
// (R11) Output mode drives pin low for data 0, releases it for data 1.
// (R12) Control bit 1 clear fades the primary sink to off and keeps it off, set turns it on.
// (R13) Without unison or panel mode, control bit 2 clear fades the secondary sink to off and keeps it off, set turns it on.
// (R14) Only the five low bits of each level register set the code.
// (R15) Rate select comes from control bits 3 and 4.
// (R16) Unison makes both sinks follow the primary level code; panel mode fades the secondary sink to off and keeps it off.
// (R17) Dwell comes from a reloaded counter; code holds while it runs.
`timescale 1ns/1ps
`include "lbr_map.svh"
`default_nettype none

module lbr_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h36, // Arbitrary bus address
  parameter int unsigned STEP0_CYC = `LBR_STEP0_US * `LBR_CLK_MHZ,
  parameter int unsigned STEP1_CYC = `LBR_STEP1_MS * 1000 * `LBR_CLK_MHZ,
  parameter int unsigned STEP2_CYC = `LBR_STEP2_MS * 1000 * `LBR_CLK_MHZ,
  parameter int unsigned STEP3_CYC = `LBR_STEP3_MS * 1000 * `LBR_CLK_MHZ,
  parameter int unsigned CNT_W = 23
) (
  // Clock, reset, enable
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // Two-wire serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Shared reset / general pin
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe_n_out,
  // Current sinks
  output lbr_pkg::lbr_code_t primary_level_out,
  output lbr_pkg::lbr_code_t secondary_level_out,
  output logic primary_sink_en_out,
  output logic secondary_sink_en_out,
  output logic panel_supply_select_out
);
  import lbr_pkg::*;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [1:0] scl_sync, sda_sync, gpio_sync;
  logic scl_d, sda_d;
  logic scl_s, sda_s, gpio_s;
  assign scl_s = scl_sync[1];
  assign sda_s = sda_sync[1];
  assign gpio_s = gpio_sync[1];

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      gpio_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (ce_in) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      gpio_sync <= {gpio_sync[0], gpio_in};
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [5:0] ctrl;
  logic [7:0] lvl_p, lvl_s;
  logic [2:0] pf;
  logic pin_rst, wr_stb;
  logic [7:0] ptr, shreg, rd_data;
  lbr_bus_state_t state;
  logic [3:0] bitcnt;

  // Pin clears control, levels, codes and bus state, but keeps pin function, while in reset function
  assign pin_rst = ~pf[`LBR_PF_ENABLE] & ~gpio_s; // R9

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    case (a)
      `LBR_OFS_CTRL: rd_reg = {`LBR_CTRL_FILL, ctrl};
      `LBR_OFS_PRIMARY: rd_reg = lvl_p;
      `LBR_OFS_SECONDARY: rd_reg = lvl_s;
      `LBR_OFS_PIN_FUNC: rd_reg = {5'h00,
        (pf[`LBR_PF_ENABLE] & ~pf[`LBR_PF_MODE]) ? gpio_s : pf[`LBR_PF_DATA], // R10
        pf[1:0]};
      default: rd_reg = 8'h00;
    endcase
  endfunction
  // Function reads register state, so a process keeps it sensitive to it
  always_comb begin
    rd_data = rd_reg(ptr);
  end

  assign wr_stb = ce_in & ~pin_rst & ~bus_stop & ~bus_start & scl_fall
    & (state == LBR_WDATA) & (bitcnt == 4'h8);

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ctrl <= `LBR_CTRL_RESET;
      lvl_p <= `LBR_LEVEL_RESET;
      lvl_s <= `LBR_LEVEL_RESET;
      pf <= `LBR_PF_RESET; // R9
    end else if (ce_in) begin
      if (pin_rst) begin
        ctrl <= `LBR_CTRL_RESET;
        lvl_p <= `LBR_LEVEL_RESET;
        lvl_s <= `LBR_LEVEL_RESET;
      end else if (wr_stb) begin
        case (ptr)
          `LBR_OFS_CTRL: ctrl <= shreg[5:0];
          `LBR_OFS_PRIMARY: lvl_p <= shreg;
          `LBR_OFS_SECONDARY: lvl_s <= shreg;
          `LBR_OFS_PIN_FUNC: pf <= shreg[2:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Serial bus slave
  // ----------------------------------------
  logic rw, sda_drv;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= LBR_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_drv <= 1'b0;
    end else if (ce_in) begin
      if (pin_rst || bus_stop) begin
        state <= LBR_IDLE;
        sda_drv <= 1'b0;
      end else if (bus_start) begin
        state <= LBR_ADDR;
        bitcnt <= 4'h0;
        sda_drv <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          LBR_ADDR, LBR_REG, LBR_WDATA: begin
            shreg <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end
          LBR_RACK: if (sda_s) state <= LBR_IDLE;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          LBR_ADDR: if (bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            if (shreg[7:1] == DEV_ADDR) begin
              state <= LBR_ACK_A;
              rw <= shreg[0];
              sda_drv <= 1'b1;
            end else begin
              state <= LBR_IDLE;
            end
          end
          LBR_REG: if (bitcnt == 4'h8) begin
            ptr <= shreg;
            state <= LBR_ACK_R;
            sda_drv <= 1'b1;
            bitcnt <= 4'h0;
          end
          LBR_WDATA: if (bitcnt == 4'h8) begin
            ptr <= ptr + 8'h01;
            state <= LBR_ACK_W;
            sda_drv <= 1'b1;
            bitcnt <= 4'h0;
          end
          LBR_ACK_A, LBR_RACK: begin
            if (rw) begin
              shreg <= rd_data;
              ptr <= ptr + 8'h01;
              sda_drv <= ~rd_data[7];
              state <= LBR_RDATA;
              bitcnt <= 4'h0;
            end else begin
              state <= LBR_REG;
              sda_drv <= 1'b0;
            end
          end
          LBR_ACK_R, LBR_ACK_W: begin
            state <= LBR_WDATA;
            sda_drv <= 1'b0;
          end
          LBR_RDATA: begin
            if (bitcnt == 4'h7) begin
              state <= LBR_RACK;
              sda_drv <= 1'b0;
            end else begin
              bitcnt <= bitcnt + 4'h1;
              shreg <= {shreg[6:0], 1'b0};
              sda_drv <= ~shreg[6];
            end
          end
          default: state <= LBR_IDLE;
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n_out = ~sda_drv;
  assign gpio_out = 1'b0;
  // Open drain: only ever pulls low
  assign gpio_oe_n_out = ~(pf[`LBR_PF_ENABLE] & pf[`LBR_PF_MODE] & ~pf[`LBR_PF_DATA]); // R11
  assign panel_supply_select_out = ctrl[`LBR_CTRL_PANEL];

  // ----------------------------------------
  // Ramp engines
  // ----------------------------------------
  function automatic logic [CNT_W-1:0] step_cycles(input logic [1:0] sel);
    case (sel)
      2'h0: step_cycles = CNT_W'(STEP0_CYC);
      2'h1: step_cycles = CNT_W'(STEP1_CYC);
      2'h2: step_cycles = CNT_W'(STEP2_CYC);
      default: step_cycles = CNT_W'(STEP3_CYC);
    endcase
  endfunction

  logic [CNT_W-1:0] dwell;
  logic [1:0] on_eff;
  lbr_code_t goal [2];
  lbr_code_t act [2];
  lbr_code_t tgt [2];
  logic [CNT_W-1:0] cnt [2];
  logic [1:0] sink_en;

  // Rate bits read as {lo, hi} to match the dwell table
  assign dwell = step_cycles({ctrl[`LBR_CTRL_RATE_LO], ctrl[`LBR_CTRL_RATE_HI]}); // R1 R15
  assign on_eff[0] = ctrl[`LBR_CTRL_PRIMARY_ON]; // R12
  // Panel supply mode turns the secondary pin into feedback
  assign on_eff[1] = ~ctrl[`LBR_CTRL_PANEL] & (ctrl[`LBR_CTRL_UNISON] ?
    ctrl[`LBR_CTRL_PRIMARY_ON] : ctrl[`LBR_CTRL_SECONDARY_ON]); // R13
  assign goal[0] = on_eff[0] ? lvl_p[4:0] : 5'h00; // R14 R5
  assign goal[1] = on_eff[1] ?
    (ctrl[`LBR_CTRL_UNISON] ? lvl_p[4:0] : lvl_s[4:0]) : 5'h00; // R16 R14

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sink
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          tgt[gi] <= 5'h00;
        end else if (ce_in) begin
          if (pin_rst || !on_eff[gi]) begin
            tgt[gi] <= 5'h00; // R6
          end else if (act[gi] == tgt[gi]) begin
            tgt[gi] <= goal[gi]; // R7 R2
          end
        end
      end

      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          act[gi] <= 5'h00;
          cnt[gi] <= '0;
        end else if (ce_in) begin
          if (pin_rst) begin
            act[gi] <= 5'h00;
            cnt[gi] <= '0;
          end else if (act[gi] == tgt[gi]) begin
            cnt[gi] <= '0; // R4
          end else if (cnt[gi] != '0) begin
            cnt[gi] <= cnt[gi] - CNT_W'(1); // R17
          end else begin
            act[gi] <= (act[gi] < tgt[gi]) ? act[gi] + 5'h01 : act[gi] - 5'h01; // R3
            cnt[gi] <= dwell - CNT_W'(1); // R8 R17
          end
        end
      end

      // Sink stays live until a fade has reached zero
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          sink_en[gi] <= 1'b0;
        end else if (ce_in) begin
          sink_en[gi] <= on_eff[gi] | (act[gi] != 5'h00); // R12 R13
        end
      end

      step_one_code_a: assert property ($changed(act[gi]) |->
          (act[gi] == $past(act[gi]) + 5'h01) || (act[gi] == $past(act[gi]) - 5'h01)) // R3
        else $error("code moved by more than one");
      dwell_hold_a: assert property ((ce_in && cnt[gi] != '0 && !pin_rst) |=> $stable(act[gi])) // R17
        else $error("code moved during dwell");
      step_reload_a: assert property ((ce_in && !pin_rst && act[gi] != tgt[gi] && cnt[gi] == '0)
          |=> (act[gi] != $past(act[gi])) && (cnt[gi] == $past(dwell) - CNT_W'(1))) // R1
        else $error("step did not reload dwell");
      fade_off_a: assert property ((ce_in && !on_eff[gi]) |=> tgt[gi] == 5'h00) // R6
        else $error("disabled sink not heading to zero");
      finish_first_a: assert property ((ce_in && on_eff[gi] && !pin_rst && act[gi] != tgt[gi])
          |=> tgt[gi] == $past(tgt[gi])) // R7
        else $error("target replaced mid-ramp");
      first_step_a: assert property ((ce_in && !pin_rst && on_eff[gi] && act[gi] == tgt[gi]
          && goal[gi] != act[gi]) ##1 ce_in |=> act[gi] != $past(act[gi], 2)) // R4
        else $error("first step waited a dwell");
    end
  endgenerate

  assign primary_level_out = act[0];
  assign secondary_level_out = act[1];
  assign primary_sink_en_out = sink_en[0];
  assign secondary_sink_en_out = sink_en[1];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  pin_drive_a: assert property (!gpio_oe_n_out |->
      pf[`LBR_PF_ENABLE] && pf[`LBR_PF_MODE] && !pf[`LBR_PF_DATA]) // R11
    else $error("shared pin driven outside output mode");
  pin_reset_a: assert property ((ce_in && pin_rst) |=>
      ctrl == `LBR_CTRL_RESET && act[0] == 5'h00 && act[1] == 5'h00) // R9
    else $error("pin reset did not clear state");
  unison_a: assert property ((ctrl[`LBR_CTRL_UNISON] && !ctrl[`LBR_CTRL_PANEL]) |->
      goal[1] == goal[0]) // R16
    else $error("unison sinks disagree");
  sink_off_a: assert property ((!on_eff[0] && act[0] == 5'h00 && ce_in) ##1
      (!on_eff[0] && act[0] == 5'h00) |-> !primary_sink_en_out) // R12
    else $error("primary sink left on");
  read_pin_a: assert property ((pf[`LBR_PF_ENABLE] && !pf[`LBR_PF_MODE]
      && ptr == `LBR_OFS_PIN_FUNC) |-> rd_data[2] == gpio_s) // R10
    else $error("pin level not returned");

  full_ramp_c: cover property (act[0] == 5'h1F ##[1:1000] act[0] == 5'h00);
  bus_write_c: cover property (wr_stb && ptr == `LBR_OFS_CTRL);
  bus_read_c: cover property (state == LBR_RDATA ##[1:1000] state == LBR_RACK);
  unison_c: cover property (ctrl[`LBR_CTRL_UNISON] && act[1] != 5'h00);
endmodule

`default_nettype wire

// File: tb/lbr_host.sv
// Two-wire bus host model for register access
`timescale 1ns/1ps
`default_nettype none
module lbr_host #(
  parameter logic [6:0] ADDR = 7'h36
) (
  // Clock and bus wires
  input wire logic clock_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // Quarter bit of four clocks keeps each SCL phase above the sampling floor
  task automatic q;
    repeat (4) @(negedge clock_in);
  endtask
  task automatic start;
    sda_low_out = 1'b0;
    q;
    scl_out = 1'b1;
    q;
    sda_low_out = 1'b1;
    q;
    scl_out = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low_out = 1'b1;
    q;
    scl_out = 1'b1;
    q;
    sda_low_out = 1'b0;
    q;
  endtask
  // Eight bits MSB first, then a released ninth bit
  task automatic xfer(input logic [7:0] d, output logic [7:0] r);
    logic [8:0] s;
    for (int i = 8; i >= 0; i--) begin
      sda_low_out = (i > 0) ? !d[i - 1] : 1'b0;
      q;
      scl_out = 1'b1;
      q;
      s[i] = sda_in;
      q;
      scl_out = 1'b0;
      q;
    end
    r = s[8:1];
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    start;
    xfer({ADDR, 1'b0}, r);
    xfer(a, r);
    xfer(d, r);
    stop;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] r;
    start;
    xfer({ADDR, 1'b0}, r);
    xfer(a, r);
    start;
    xfer({ADDR, 1'b1}, r);
    xfer(8'hFF, d);
    stop;
  endtask
endmodule
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the brightness ramp controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lbr_pkg::*;
  // ----
  // Signals and model state
  // ----
  logic clock_in = 1'b0;
  logic reset_n = 1'b0;
  logic gpio_low = 1'b0;
  logic mon = 1'b0;
  logic fade = 1'b0;
  logic ce = 1'b1;
  logic scl, sda_low, sda_oe_n, gpio_oe_n, pen, sen;
  lbr_code_t plev, slev, prev, pmax;
  logic [7:0] rv;
  logic [31:0] v;
  int mismatches = 0;
  int compares = 0;
  int seed = 47;
  int dw_now = 8;
  int dw_old = 8;
  int cyc = 0;
  int last_t = -100;
  int last_dir = 0;
  int dir, gap;
  // Pull-ups on both open-drain lines
  wire logic sda = !(sda_low || sda_oe_n === 1'b0);
  wire logic gpio = !(gpio_low || gpio_oe_n === 1'b0);
  initial forever #4 clock_in = !clock_in;
  // Short dwells keep the run brief
  lbr_ctrl #(.STEP0_CYC(8), .STEP1_CYC(16), .STEP2_CYC(24), .STEP3_CYC(32)) u_lbr_ctrl (
    .clock_in(clock_in), .reset_n_in(reset_n), .ce_in(ce), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe_n_out(sda_oe_n), .gpio_in(gpio), .gpio_out(),
    .gpio_oe_n_out(gpio_oe_n), .primary_level_out(plev), .secondary_level_out(slev),
    .primary_sink_en_out(pen), .secondary_sink_en_out(sen), .panel_supply_select_out());
  lbr_host u_lbr_host (.clock_in(clock_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  // ----
  // Helpers
  // ----
  function automatic int dwell(input logic [7:0] c);
    return 8 * (c[3] * 2 + c[4] + 1);
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Either dwell is legal while the rate write is in flight
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h00) dw_now = dwell(d);
    u_lbr_host.write_reg(a, d);
    // A dwell loaded at the old rate may still be running
    repeat (dw_old) @(negedge clock_in);
    dw_old = dw_now;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_lbr_host.read_reg(a, rv);
    check(rv, exp);
  endtask
  task automatic wait_lvl(input logic sel, input lbr_code_t c);
    for (int i = 0; i < 3000 && (sel ? slev : plev) !== c; i++) @(negedge clock_in);
    // Sink enable trails the code by one clock
    @(negedge clock_in);
    check(sel ? slev : plev, c);
  endtask
  // ----
  // Step monitor
  // ----
  always @(negedge clock_in) begin
    cyc++;
    if (mon && plev !== prev) begin
      dir = (plev > prev) ? 1 : -1;
      gap = cyc - last_t;
      check(dir > 0 ? plev - prev : prev - plev, 8'h01);
      if (gap <= 40 && dir == last_dir) check(gap == dw_now || gap == dw_old, 1);
      if (gap <= 40 && dir != last_dir) check(gap == (fade ? dw_now : 2), 1);
      if (plev > pmax) pmax = plev;
      last_t = cyc;
      last_dir = dir;
    end
    prev = plev;
  end
  initial begin
    repeat (90000) @(posedge clock_in);
    mismatches++;
    print_verdict;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    repeat (3) @(negedge clock_in);
    reset_n = 1'b1;
    repeat (4) @(negedge clock_in);
    mon = 1'b1;
    rd(8'h00, 8'hC0);
    rd(8'h03, 8'h00);
    check(gpio_oe_n, 1);
    for (int r = 0; r < 4; r++) begin
      wr(8'h01, 8'h08);
      wr(8'h00, 8'(8'h02 | (r << 3)));
      wait_lvl(0, 5'h08);
      check(pen, 1);
      rd(8'h00, 8'(8'hC2 | (r << 3)));
      wr(8'h00, 8'(r << 3));
      wait_lvl(0, 5'h00);
      check(pen, 0);
    end
    fade = 1'b1;
    wr(8'h01, 8'h1F);
    pmax = 5'h00;
    wr(8'h00, 8'h1A);
    wr(8'h00, 8'h18);
    wait_lvl(0, 5'h00);
    check(pmax < 5'h1F, 1);
    fade = 1'b0;
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h1A);
    wait_lvl(0, 5'h01);
    wr(8'h01, 8'h1F);
    wr(8'h01, 8'h09);
    wait_lvl(0, 5'h1F);
    wr(8'h00, 8'h02);
    wait_lvl(0, 5'h09);
    wr(8'h00, 8'h07);
    wr(8'h01, 8'hE5);
    wait_lvl(0, 5'h05);
    check(slev, 8'h05);
    check(sen, 1);
    wr(8'h02, 8'h03);
    check(slev, 8'h05);
    wr(8'h00, 8'h04);
    wait_lvl(1, 5'h03);
    wait_lvl(0, 5'h00);
    check(pen, 0);
    wr(8'h00, 8'h00);
    wait_lvl(1, 5'h00);
    check(sen, 0);
    wr(8'h00, 8'h02);
    repeat (4) begin
      v = $random(seed);
      wr(8'h01, v[7:0]);
      wait_lvl(0, v[4:0]);
    end
    wr(8'h10, 8'h5A);
    rd(8'h10, 8'h00);
    wr(8'h03, 8'h01);
    gpio_low = 1'b1;
    rd(8'h03, 8'h01);
    gpio_low = 1'b0;
    rd(8'h03, 8'h05);
    wr(8'h03, 8'h03);
    check(gpio_oe_n, 0);
    wr(8'h03, 8'h07);
    check(gpio_oe_n, 1);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h1F);
    wait_lvl(0, 5'h1F);
    // Codes jump at once here, so the step monitor stands aside
    mon = 1'b0;
    // Enable low freezes the synchronisers, so the pin reset waits
    ce = 1'b0;
    gpio_low = 1'b1;
    repeat (6) @(negedge clock_in);
    check(plev, 8'h1F);
    ce = 1'b1;
    repeat (6) @(negedge clock_in);
    check(plev, 8'h00);
    gpio_low = 1'b0;
    repeat (4) @(negedge clock_in);
    rd(8'h00, 8'hC0);
    print_verdict;
  end
endmodule
`default_nettype wire
